//--- design/freq_limit_pkg.sv
// Constants, register map and bus carrier types of the output frequency limiter
package freq_limit_pkg;

    // ----------------------------------------------------------------
    // Frequency units: 0.1 Hz per count
    // ----------------------------------------------------------------
    localparam int FREQ_W = 16;
    localparam logic [15:0] F_0HZ = 16'h0000;
    localparam logic [15:0] F_50HZ = 16'h01F4;
    localparam logic [15:0] F_120HZ = 16'h04B0;
    localparam logic [15:0] F_400HZ = 16'h0FA0;
    localparam logic [15:0] JUMP_OFF = 16'h270F;
    localparam logic [15:0] START_FREQ_RST = 16'h0005;
    localparam logic [15:0] JOG_FREQ_RST = 16'h0032;
    localparam logic [15:0] STEP_CYCLES_RST = 16'h0100;
    localparam int ANALOG_W = 10;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MAX_FREQ = 8'h00;
    localparam logic [7:0] ADDR_MIN_FREQ = 8'h04;
    localparam logic [7:0] ADDR_HS_MAX = 8'h08;
    localparam logic [7:0] ADDR_START_FREQ = 8'h0C;
    localparam logic [7:0] ADDR_JOG_FREQ = 8'h10;
    localparam logic [7:0] ADDR_JUMP_FIRST = 8'h14;
    localparam logic [7:0] ADDR_JUMP_LAST = 8'h28;
    localparam logic [7:0] ADDR_GAIN2 = 8'h2C;
    localparam logic [7:0] ADDR_GAIN4 = 8'h30;
    localparam logic [7:0] ADDR_GROUP_SEL = 8'h34;
    localparam logic [7:0] ADDR_CTRL = 8'h38;
    localparam logic [7:0] ADDR_CMD_FREQ = 8'h3C;
    localparam logic [7:0] ADDR_STEP = 8'h40;
    localparam logic [7:0] ADDR_STATUS = 8'h44;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_JOG = 1;
    localparam int CTRL_SRC_LO = 2;
    localparam logic [1:0] SRC_DIGITAL = 2'h0;
    localparam logic [1:0] SRC_IN2 = 2'h1;
    localparam logic [1:0] SRC_IN4 = 2'h2;

    // ----------------------------------------------------------------
    // Bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

endpackage : freq_limit_pkg

//--- design/output_frequency_limiter.sv
// Output frequency limiter with jump bands, ramp and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Command above maximum is clamped to maximum
// - Writing high-speed maximum also overwrites maximum
// - Command below minimum is held at minimum
// - Jog at or below minimum ignores minimum
// - Start without command ramps to minimum frequency
// - Three jump bands, A and B each
// - Jump setting 9999 disables its band
// - Command inside band runs at A setting
// - A at lower edge holds command low
// - A at upper edge raises command high
// - Ramp passes through bands; target substituted only
// - Limit and jump settings writable only when group select is 0
// - Analog command scaled by gain frequency
module output_frequency_limiter
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire freq_limit_pkg::axil_req_t bus_req,
    output freq_limit_pkg::axil_rsp_t bus_rsp,
    // Analog frequency inputs
    input wire logic [freq_limit_pkg::ANALOG_W-1:0] analog_in2,
    input wire logic [freq_limit_pkg::ANALOG_W-1:0] analog_in4,
    // Ramp output
    output logic [15:0] running_freq,
    output logic [15:0] target_freq,
    output logic at_target
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] max_freq_limit;
        logic [15:0] min_freq_limit;
        logic [15:0] high_speed_max_limit;
        logic [15:0] starting_freq;
        logic [15:0] jog_freq;
        logic [5:0][15:0] jump;
        logic [15:0] analog_in2_gain_freq;
        logic [15:0] analog_in4_gain_freq;
        logic [15:0] user_group_read_select;
        logic [3:0] ctrl;
        logic [15:0] cmd_freq;
        logic [15:0] step_cycles;
        logic [15:0] run_f;
        logic [15:0] tgt;
        logic [15:0] tick;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s;
    state_t next_s;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r[7:0] = strb[0] ? d[7:0] : old[7:0];
        r[15:8] = strb[1] ? d[15:8] : old[15:8];
        return r;
    endfunction : merge16

    function automatic logic [15:0] jump_apply(input logic [15:0] f, input logic [15:0] a,
                                               input logic [15:0] b);
        logic [15:0] lo;
        logic [15:0] hi;
        lo = (a < b) ? a : b;
        hi = (a < b) ? b : a;
        if (a == freq_limit_pkg::JUMP_OFF || b == freq_limit_pkg::JUMP_OFF)
        begin
            return f;
        end
        return (f >= lo && f <= hi) ? a : f;
    endfunction : jump_apply

    function automatic logic [15:0] analog_scale(input logic [9:0] raw, input logic [15:0] gain);
        logic [25:0] p;
        p = raw * gain;
        return p[25:10];
    endfunction : analog_scale

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return v >= lo && v <= hi;
    endfunction : in_range

    // ----------------------------------------------------------------
    // Target computation
    // ----------------------------------------------------------------
    logic [15:0] cmd_sel;
    logic [15:0] jumped;
    logic [15:0] clamped;
    logic [15:0] tgt_now;
    logic [15:0] wval;

    always_comb
    begin
        unique case (s.ctrl[freq_limit_pkg::CTRL_SRC_LO +: 2])
            freq_limit_pkg::SRC_IN2: cmd_sel = analog_scale(analog_in2, s.analog_in2_gain_freq);
            freq_limit_pkg::SRC_IN4: cmd_sel = analog_scale(analog_in4, s.analog_in4_gain_freq);
            default: cmd_sel = s.cmd_freq;
        endcase
        jumped = cmd_sel;
        for (int i = 0; i < 3; i++)
        begin
            jumped = jump_apply(jumped, s.jump[2 * i], s.jump[2 * i + 1]);
        end
        clamped = jumped;
        if (clamped > s.max_freq_limit)
        begin
            clamped = s.max_freq_limit;
        end
        if (clamped < s.min_freq_limit)
        begin
            clamped = s.min_freq_limit;
        end
        if (s.ctrl[freq_limit_pkg::CTRL_JOG])
        begin
            clamped = (s.jog_freq > s.max_freq_limit) ? s.max_freq_limit : s.jog_freq;
        end
        tgt_now = (!s.ctrl[freq_limit_pkg::CTRL_RUN] || clamped < s.starting_freq)
                  ? freq_limit_pkg::F_0HZ : clamped;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic wr_ok;
        logic unlocked;
        wr_ok = 1'b0;
        unlocked = 1'b0;
        next_s = s;
        wval = merge16(16'h0000, s.w_data, s.w_strb);

        // Ramp: running value moves linearly, bands are crossed freely
        next_s.tgt = tgt_now;
        if (s.run_f == s.tgt)
        begin
            next_s.tick = 16'h0000;
        end
        else if (s.tick >= s.step_cycles)
        begin
            next_s.tick = 16'h0000;
            next_s.run_f = (s.run_f < s.tgt) ? s.run_f + 16'h0001 : s.run_f - 16'h0001;
        end
        else
        begin
            next_s.tick = s.tick + 16'h0001;
        end

        // Write address and data capture, either order
        if (bus_req.awvalid && bus_rsp.awready)
        begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = bus_req.awaddr;
        end
        if (bus_req.wvalid && bus_rsp.wready)
        begin
            next_s.w_held = 1'b1;
            next_s.w_data = bus_req.wdata;
            next_s.w_strb = bus_req.wstrb;
        end
        if (s.bvalid && bus_req.bready)
        begin
            next_s.bvalid = 1'b0;
        end

        // Register write
        if (s.aw_held && s.w_held && !s.bvalid)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = freq_limit_pkg::RESP_OKAY;
            unlocked = (s.user_group_read_select == 16'h0000);
            unique case (s.aw_addr)
                freq_limit_pkg::ADDR_MAX_FREQ, freq_limit_pkg::ADDR_MIN_FREQ:
                    wr_ok = unlocked && in_range(wval, freq_limit_pkg::F_0HZ,
                                                 freq_limit_pkg::F_120HZ);
                freq_limit_pkg::ADDR_HS_MAX:
                    wr_ok = unlocked && in_range(wval, freq_limit_pkg::F_120HZ,
                                                 freq_limit_pkg::F_400HZ);
                freq_limit_pkg::ADDR_START_FREQ, freq_limit_pkg::ADDR_JOG_FREQ,
                freq_limit_pkg::ADDR_GAIN2, freq_limit_pkg::ADDR_GAIN4:
                    wr_ok = in_range(wval, freq_limit_pkg::F_0HZ, freq_limit_pkg::F_400HZ);
                freq_limit_pkg::ADDR_GROUP_SEL, freq_limit_pkg::ADDR_CTRL,
                freq_limit_pkg::ADDR_CMD_FREQ, freq_limit_pkg::ADDR_STEP:
                    wr_ok = 1'b1;
                default:
                    wr_ok = unlocked && s.aw_addr >= freq_limit_pkg::ADDR_JUMP_FIRST
                            && s.aw_addr <= freq_limit_pkg::ADDR_JUMP_LAST
                            && s.aw_addr[1:0] == 2'h0
                            && (in_range(wval, freq_limit_pkg::F_0HZ, freq_limit_pkg::F_400HZ)
                                || wval == freq_limit_pkg::JUMP_OFF);
            endcase
            if (!wr_ok)
            begin
                next_s.bresp = (s.aw_addr > freq_limit_pkg::ADDR_STATUS || s.aw_addr[1:0] != 2'h0)
                               ? freq_limit_pkg::RESP_DECERR : freq_limit_pkg::RESP_SLVERR;
            end
            else
            begin
                unique case (s.aw_addr)
                    freq_limit_pkg::ADDR_MAX_FREQ: next_s.max_freq_limit = wval;
                    freq_limit_pkg::ADDR_MIN_FREQ: next_s.min_freq_limit = wval;
                    freq_limit_pkg::ADDR_HS_MAX:
                    begin
                        next_s.high_speed_max_limit = wval;
                        next_s.max_freq_limit = wval;
                    end
                    freq_limit_pkg::ADDR_START_FREQ: next_s.starting_freq = wval;
                    freq_limit_pkg::ADDR_JOG_FREQ: next_s.jog_freq = wval;
                    freq_limit_pkg::ADDR_GAIN2: next_s.analog_in2_gain_freq = wval;
                    freq_limit_pkg::ADDR_GAIN4: next_s.analog_in4_gain_freq = wval;
                    freq_limit_pkg::ADDR_GROUP_SEL: next_s.user_group_read_select = wval;
                    freq_limit_pkg::ADDR_CTRL:
                        next_s.ctrl = s.w_strb[0] ? s.w_data[3:0] : s.ctrl;
                    freq_limit_pkg::ADDR_CMD_FREQ: next_s.cmd_freq = wval;
                    freq_limit_pkg::ADDR_STEP: next_s.step_cycles = wval;
                    default:
                        next_s.jump[3'((s.aw_addr - freq_limit_pkg::ADDR_JUMP_FIRST) >> 2)]
                            = wval;
                endcase
            end
        end

        // Register read
        if (s.rvalid && bus_req.rready)
        begin
            next_s.rvalid = 1'b0;
        end
        if (bus_req.arvalid && bus_rsp.arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = freq_limit_pkg::RESP_OKAY;
            next_s.rdata = 32'h00000000;
            unique case (bus_req.araddr)
                freq_limit_pkg::ADDR_MAX_FREQ: next_s.rdata[15:0] = s.max_freq_limit;
                freq_limit_pkg::ADDR_MIN_FREQ: next_s.rdata[15:0] = s.min_freq_limit;
                freq_limit_pkg::ADDR_HS_MAX: next_s.rdata[15:0] = s.high_speed_max_limit;
                freq_limit_pkg::ADDR_START_FREQ: next_s.rdata[15:0] = s.starting_freq;
                freq_limit_pkg::ADDR_JOG_FREQ: next_s.rdata[15:0] = s.jog_freq;
                freq_limit_pkg::ADDR_GAIN2: next_s.rdata[15:0] = s.analog_in2_gain_freq;
                freq_limit_pkg::ADDR_GAIN4: next_s.rdata[15:0] = s.analog_in4_gain_freq;
                freq_limit_pkg::ADDR_GROUP_SEL: next_s.rdata[15:0] = s.user_group_read_select;
                freq_limit_pkg::ADDR_CTRL: next_s.rdata[3:0] = s.ctrl;
                freq_limit_pkg::ADDR_CMD_FREQ: next_s.rdata[15:0] = s.cmd_freq;
                freq_limit_pkg::ADDR_STEP: next_s.rdata[15:0] = s.step_cycles;
                freq_limit_pkg::ADDR_STATUS: next_s.rdata = {s.tgt, s.run_f};
                default:
                begin
                    if (bus_req.araddr >= freq_limit_pkg::ADDR_JUMP_FIRST
                        && bus_req.araddr <= freq_limit_pkg::ADDR_JUMP_LAST
                        && bus_req.araddr[1:0] == 2'h0)
                    begin
                        next_s.rdata[15:0] =
                            s.jump[3'((bus_req.araddr - freq_limit_pkg::ADDR_JUMP_FIRST) >> 2)];
                    end
                    else
                    begin
                        next_s.rresp = freq_limit_pkg::RESP_DECERR;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.max_freq_limit <= freq_limit_pkg::F_120HZ;
            s.min_freq_limit <= freq_limit_pkg::F_0HZ;
            s.high_speed_max_limit <= freq_limit_pkg::F_120HZ;
            s.starting_freq <= freq_limit_pkg::START_FREQ_RST;
            s.jog_freq <= freq_limit_pkg::JOG_FREQ_RST;
            s.jump <= {6{freq_limit_pkg::JUMP_OFF}};
            s.analog_in2_gain_freq <= freq_limit_pkg::F_50HZ;
            s.analog_in4_gain_freq <= freq_limit_pkg::F_50HZ;
            s.step_cycles <= freq_limit_pkg::STEP_CYCLES_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_comb
    begin
        bus_rsp.awready = !s.aw_held && !s.bvalid;
        bus_rsp.wready = !s.w_held && !s.bvalid;
        bus_rsp.bvalid = s.bvalid;
        bus_rsp.bresp = s.bresp;
        bus_rsp.arready = !s.rvalid;
        bus_rsp.rvalid = s.rvalid;
        bus_rsp.rdata = s.rdata;
        bus_rsp.rresp = s.rresp;
        running_freq = s.run_f;
        target_freq = s.tgt;
        at_target = (s.run_f == s.tgt);
    end

endmodule : output_frequency_limiter

`default_nettype wire

//--- tb/output_frequency_limiter_props.sv
// Concurrent checks on the ports of the output frequency limiter
`timescale 1ns/1ps
`default_nettype none
module output_frequency_limiter_props
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire freq_limit_pkg::axil_req_t bus_req,
    input wire freq_limit_pkg::axil_rsp_t bus_rsp,
    // Ramp output
    input wire logic [15:0] running_freq,
    input wire logic [15:0] target_freq,
    input wire logic at_target
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Bus steps
    // ----------------------------------------------------------------
    sequence ar_taken;
        bus_req.arvalid && bus_rsp.arready;
    endsequence
    sequence rd_answer;
        bus_rsp.rvalid && !bus_rsp.arready;
    endsequence
    sequence wr_taken;
        bus_req.awvalid && bus_rsp.awready && bus_req.wvalid && bus_rsp.wready;
    endsequence

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    read_latency_a: assert property (ar_taken |=> rd_answer)
        else $error("read answer late");
    write_resp_a: assert property (wr_taken |-> ##[1:2] bus_rsp.bvalid)
        else $error("write answer late");
    bresp_hold_a: assert property (bus_rsp.bvalid && !bus_req.bready
        |=> bus_rsp.bvalid && $stable(bus_rsp.bresp))
        else $error("write answer dropped");
    rdata_hold_a: assert property (bus_rsp.rvalid && !bus_req.rready
        |=> bus_rsp.rvalid && $stable(bus_rsp.rdata))
        else $error("read answer dropped");
    at_target_a: assert property (at_target == (running_freq == target_freq))
        else $error("settled flag wrong");
    ramp_step_a: assert property (running_freq == $past(running_freq)
        || running_freq == $past(running_freq) + 16'h0001
        || running_freq == $past(running_freq) - 16'h0001)
        else $error("running frequency jumped");
    ramp_dir_a: assert property (running_freq < target_freq
        |=> running_freq >= $past(running_freq))
        else $error("ramp moved away from target");
    target_range_a: assert property (target_freq <= freq_limit_pkg::F_400HZ)
        else $error("target above limit");
    settled_hold_a: assert property (at_target |=> $stable(running_freq))
        else $error("running frequency moved while settled");
endmodule : output_frequency_limiter_props

bind output_frequency_limiter output_frequency_limiter_props i_props
(
    .core_clk(core_clk),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .running_freq(running_freq),
    .target_freq(target_freq),
    .at_target(at_target)
);
`default_nettype wire

//--- tb/analog_cmd_source.sv
// Analog frequency command source feeding both analog inputs
`timescale 1ns/1ps
`default_nettype none
module analog_cmd_source
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Requested level
    input wire logic [9:0] level,
    // Analog samples
    output logic [9:0] in2,
    output logic [9:0] in4
);
    // Second input carries half the level
    always_ff @(posedge core_clk)
    begin
        in2 <= rst ? 10'h000 : level;
        in4 <= rst ? 10'h000 : {1'b0, level[9:1]};
    end
endmodule : analog_cmd_source
`default_nettype wire

//--- tb/output_frequency_limiter_tb.sv
// Register-level testbench of the output frequency limiter
`timescale 1ns/1ps
`default_nettype none
module output_frequency_limiter_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    freq_limit_pkg::axil_req_t req = '0;
    freq_limit_pkg::axil_rsp_t rsp;
    logic [9:0] level = 10'h3FF;
    logic [9:0] in2;
    logic [9:0] in4;
    logic [15:0] run_f;
    logic [15:0] tgt_f;
    logic at_tgt;
    int error_cnt = 0;
    int cmp_count = 0;

    always #20 core_clk = ~core_clk;

    output_frequency_limiter i_output_frequency_limiter
    (
        .core_clk(core_clk), .rst(rst), .bus_req(req), .bus_rsp(rsp),
        .analog_in2(in2), .analog_in4(in4),
        .running_freq(run_f), .target_freq(tgt_f), .at_target(at_tgt)
    );
    analog_cmd_source i_analog_cmd_source
    (
        .core_clk(core_clk), .rst(rst), .level(level), .in2(in2), .in4(in4)
    );

    // ----------------------------------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        @(posedge core_clk);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        b = 1'b0;
        while (!b)
        begin
            @(negedge core_clk);
            aw = req.awvalid && rsp.awready;
            w = req.wvalid && rsp.wready;
            b = rsp.bvalid;
            if (b) chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
            @(posedge core_clk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (b) req.bready <= 1'b0;
        end
    endtask : wchk

    task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, r;
        @(posedge core_clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        r = 1'b0;
        while (!r)
        begin
            @(negedge core_clk);
            ar = req.arvalid && rsp.arready;
            r = rsp.rvalid;
            if (r) chk("rdata", rsp.rdata, ed);
            if (r) chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
            @(posedge core_clk);
            if (ar) req.arvalid <= 1'b0;
            if (r) req.rready <= 1'b0;
        end
    endtask : rchk

    task automatic tchk(input logic [15:0] e);
        repeat (4) @(negedge core_clk);
        chk("target", {16'h0000, tgt_f}, {16'h0000, e});
    endtask : tchk

    task automatic settle;
        int n;
        n = 0;
        while (at_tgt !== 1'b1 && n < 3000)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("settled", {31'h0, at_tgt}, 32'h1);
    endtask : settle

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        rchk(freq_limit_pkg::ADDR_MAX_FREQ, 32'h4B0, 2'h0);
        rchk(freq_limit_pkg::ADDR_MIN_FREQ, 32'h0, 2'h0);
        rchk(freq_limit_pkg::ADDR_HS_MAX, 32'h4B0, 2'h0);
        for (int k = 0; k < 6; k++)
            rchk(freq_limit_pkg::ADDR_JUMP_FIRST + 8'(4 * k), 32'h270F, 2'h0);
        rchk(8'h80, 32'h0, freq_limit_pkg::RESP_DECERR);
        rchk(freq_limit_pkg::ADDR_START_FREQ, 32'h5, 2'h0);
        rchk(freq_limit_pkg::ADDR_JOG_FREQ, 32'h32, 2'h0);
        rchk(freq_limit_pkg::ADDR_GAIN2, 32'h1F4, 2'h0);
        wchk(8'h80, 32'h1, freq_limit_pkg::RESP_DECERR);
        wchk(freq_limit_pkg::ADDR_JUMP_FIRST + 8'h02, 32'h1, freq_limit_pkg::RESP_DECERR);
        wchk(freq_limit_pkg::ADDR_STEP, 32'h1, 2'h0);
        wchk(freq_limit_pkg::ADDR_CMD_FREQ, 32'h5DC, 2'h0);
        wchk(freq_limit_pkg::ADDR_CTRL, 32'h1, 2'h0);
        tchk(16'h04B0);
        wchk(freq_limit_pkg::ADDR_HS_MAX, 32'h7D0, 2'h0);
        rchk(freq_limit_pkg::ADDR_MAX_FREQ, 32'h7D0, 2'h0);
        tchk(16'h05DC);
        wchk(freq_limit_pkg::ADDR_HS_MAX, 32'h3E8, freq_limit_pkg::RESP_SLVERR);
        wchk(freq_limit_pkg::ADDR_GROUP_SEL, 32'h1, 2'h0);
        wchk(freq_limit_pkg::ADDR_MAX_FREQ, 32'h64, freq_limit_pkg::RESP_SLVERR);
        rchk(freq_limit_pkg::ADDR_MAX_FREQ, 32'h7D0, 2'h0);
        wchk(freq_limit_pkg::ADDR_JUMP_FIRST, 32'h190, freq_limit_pkg::RESP_SLVERR);
        rchk(freq_limit_pkg::ADDR_JUMP_FIRST, 32'h270F, 2'h0);
        wchk(freq_limit_pkg::ADDR_GROUP_SEL, 32'h0, 2'h0);
        wchk(freq_limit_pkg::ADDR_MIN_FREQ, 32'h12C, 2'h0);
        wchk(freq_limit_pkg::ADDR_CMD_FREQ, 32'h64, 2'h0);
        tchk(16'h012C);
        wchk(freq_limit_pkg::ADDR_CTRL, 32'h3, 2'h0);
        tchk(16'h0032);
        wchk(freq_limit_pkg::ADDR_CMD_FREQ, 32'h0, 2'h0);
        wchk(freq_limit_pkg::ADDR_CTRL, 32'h1, 2'h0);
        tchk(16'h012C);
        settle();
        wchk(freq_limit_pkg::ADDR_CTRL, 32'h5, 2'h0);
        tchk(16'h01F3);
        wchk(freq_limit_pkg::ADDR_GAIN4, 32'h7D0, 2'h0);
        wchk(freq_limit_pkg::ADDR_CTRL, 32'h9, 2'h0);
        tchk(16'h03E6);
        wchk(freq_limit_pkg::ADDR_CTRL, 32'h1, 2'h0);
        wchk(freq_limit_pkg::ADDR_JUMP_FIRST, 32'h190, 2'h0);
        wchk(freq_limit_pkg::ADDR_JUMP_FIRST + 8'h04, 32'h1F4, 2'h0);
        wchk(freq_limit_pkg::ADDR_JUMP_FIRST + 8'h08, 32'h320, 2'h0);
        wchk(freq_limit_pkg::ADDR_JUMP_FIRST + 8'h0C, 32'h2BC, 2'h0);
        wchk(freq_limit_pkg::ADDR_JUMP_FIRST + 8'h10, 32'h258, 2'h0);
        wchk(freq_limit_pkg::ADDR_CMD_FREQ, 32'h1C2, 2'h0);
        tchk(16'h0190);
        wchk(freq_limit_pkg::ADDR_CMD_FREQ, 32'h258, 2'h0);
        tchk(16'h0258);
        wchk(freq_limit_pkg::ADDR_CMD_FREQ, 32'h2EE, 2'h0);
        tchk(16'h0320);
        settle();
        rchk(freq_limit_pkg::ADDR_STATUS, 32'h0320_0320, 2'h0);
        wchk(freq_limit_pkg::ADDR_MIN_FREQ, 32'h1C2, 2'h0);
        wchk(freq_limit_pkg::ADDR_CMD_FREQ, 32'h1C2, 2'h0);
        tchk(16'h01C2);
        report_and_stop();
    end

    initial
    begin
        #(20000 * 40);
        error_cnt++;
        report_and_stop();
    end
endmodule : output_frequency_limiter_tb
`default_nettype wire
